//--- timed_io_port.sv
// Timed I/O ports with clock blocks, pin sharing and an AHB-Lite register slave
`timescale 1ns/1ns
module timed_io_port (
   input  wire logic                      ref_clk,
   input  wire logic                      rstn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   input  wire logic [31:0]               pin_i,
   output logic      [31:0]               pin_o,
   output logic      [31:0]               pin_oe_n,
   input  wire logic [tio_pkg::NPORT-1:0] strobe_input,
   output logic      [tio_pkg::NPORT-1:0] strobe_output,
   output logic      [tio_pkg::NPORT-1:0] port_event
);
   import tio_pkg::*;

   tio_state_s q;
   tio_state_s d;
   logic [NCLK-1:0] tk;

   // ******************************
   // Next state
   // ******************************
   always_comb begin
      logic [31:0] m;
      logic [31:0] v;
      logic        go;
      logic        ok;
      logic [2:0]  sel;
      logic [1:0]  pnow;
      int          own;
      int          p;
      d = q;
      m = '0;
      v = '0;
      go = 1'b0;
      ok = 1'b0;
      sel = '0;
      own = 0;
      p = 0;
      // Two flops on every pin and strobe before use
      d.s1 = pin_i;
      d.s2 = q.s1;
      d.t1 = strobe_input;
      d.t2 = q.t1;
      pnow = {q.s2[PB[1]], q.s2[PB[0]]};
      d.pprev = pnow;
      // Clock blocks: block zero ticks every reference cycle
      tk = '0;
      tk[0] = 1'b1;
      for (int b = 1; b < NCLK; b++) begin
         case (q.ccfg[b][9:8])
            SRC_REF:  go = 1'b1;
            SRC_PIN0: go = pnow[0] & ~q.pprev[0];
            SRC_PIN1: go = pnow[1] & ~q.pprev[1];
            default:  go = 1'b0;
         endcase
         if (go) begin
            if (q.cdiv[b] == q.ccfg[b][7:0]) begin
               tk[b] = 1'b1;
               d.cdiv[b] = '0;
            end else begin
               d.cdiv[b] = q.cdiv[b] + 8'h01;
            end
         end
      end
      // Ports
      d.evt = '0;
      d.sout = '0;
      for (int i = 0; i < NPORT; i++) begin
         m = 32'hffffffff >> (32 - PW[i]);
         v = (q.s2 >> PB[i]) & m;
         sel = q.ctrl[i][F_CSEL+:3];
         go = q.ctrl[i][F_EN] && sel < 3'(NCLK) && tk[sel];
         if (go) begin
            d.cnt[i] = q.cnt[i] + 16'h0001;
         end
         case (q.ctrl[i][F_COND+:2])
            COND_EQ: ok = (v == (q.tim[i] & m[15:0])) || PW[i] > 16;
            COND_NE: ok = (v != q.rdat[i]);
            default: ok = 1'b1;
         endcase
         if (q.ctrl[i][F_OUT]) begin
            ok = 1'b1;
         end
         if (go && q.busy[i] && ok
             && (!q.ctrl[i][F_TIMED] || q.cnt[i] == q.tim[i])
             && (!q.ctrl[i][F_SIN] || q.t2[i])) begin
            d.ctrl[i][F_TIMED] = 1'b0;
            d.left[i] = q.left[i] - 6'h01;
            if (q.ctrl[i][F_OUT]) begin
               d.drv[i] = q.xfer[i] & m;
               d.xfer[i] = q.xfer[i] >> PW[i];
               d.sout[i] = q.ctrl[i][F_SOUT];
            end else begin
               d.xfer[i] = (q.xfer[i] >> PW[i]) | (v << (32 - PW[i]));
            end
            if (q.left[i] == 6'h01) begin
               d.busy[i] = 1'b0;
               d.evt[i] = 1'b1;
               d.stamp[i] = q.cnt[i];
               if (!q.ctrl[i][F_OUT]) begin
                  d.rdat[i] = d.xfer[i];
               end
            end
         end
      end
      // Pin ownership: narrowest enabled port wins, link beats all
      for (int k = 0; k < 32; k++) begin
         own = -1;
         for (int i = NPORT - 1; i >= 0; i--) begin
            if (q.ctrl[i][F_EN] && k >= PB[i] && k < PB[i] + PW[i]) begin
               own = i;
            end
         end
         d.pin_o[k] = 1'b0;
         d.pin_oe_n[k] = 1'b1;
         if (q.link_en && k >= LINK_LO) begin
            own = -1;
         end
         if (own >= 0) begin
            p = own;
            if (q.ctrl[p][F_OUT]) begin
               if (q.ctrl[p][F_OC]) begin
                  d.pin_oe_n[k] = q.drv[p][k - PB[p]];
               end else begin
                  d.pin_o[k] = q.drv[p][k - PB[p]];
                  d.pin_oe_n[k] = 1'b0;
               end
            end
         end
      end
      // ******************************
      // AHB-Lite slave, zero wait states
      // ******************************
      d.rdy = 1'b1;
      if (q.awr) begin
         p = int'(q.aaddr[6:4]);
         if (q.aaddr[11:8] == AREA_PORT && p < NPORT) begin
            case (q.aaddr[3:2])
               REG_CTRL: d.ctrl[p] = hwdata[10:0];
               REG_DATA: begin
                  d.xfer[p] = hwdata;
                  d.busy[p] = 1'b1;
                  d.left[p] = 6'(32 / PW[p]);
               end
               REG_TIME: d.tim[p] = hwdata[15:0];
               default: ;
            endcase
         end else if (q.aaddr[11:8] == AREA_CLK && q.aaddr[4:2] != 3'h0
                      && int'(q.aaddr[4:2]) < NCLK) begin
            d.ccfg[q.aaddr[4:2]] = hwdata[9:0];
         end else if (q.aaddr == OFS_GLOB) begin
            d.link_en = hwdata[0];
         end
      end
      d.awr = 1'b0;
      if (hsel && htrans[1] && hready) begin
         d.aaddr = haddr[11:0];
         d.awr = hwrite;
         d.rdata = '0;
         p = int'(haddr[6:4]);
         if (haddr[11:8] == AREA_PORT && p < NPORT) begin
            case (haddr[3:2])
               REG_CTRL:  d.rdata = {15'h0, q.busy[p], 5'h0, q.ctrl[p]};
               REG_DATA:  d.rdata = q.rdat[p];
               REG_TIME:  d.rdata = {16'h0, q.cnt[p]};
               REG_STAMP: d.rdata = {16'h0, q.stamp[p]};
               default:   d.rdata = '0;
            endcase
         end else if (haddr[11:8] == AREA_CLK && int'(haddr[4:2]) < NCLK) begin
            d.rdata = {22'h0, q.ccfg[haddr[4:2]]};
         end else if (haddr[11:0] == OFS_GLOB) begin
            d.rdata = {31'h0, q.link_en};
         end
      end
   end

   // ******************************
   // State register
   // ******************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q <= '0;
         q.rdy <= 1'b1;
         q.pin_oe_n <= '1;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.rdata;
   assign hreadyout = q.rdy;
   assign hresp = 1'b0;
   assign pin_o = q.pin_o;
   assign pin_oe_n = q.pin_oe_n;
   assign strobe_output = q.sout;
   assign port_event = q.evt;

   // ******************************
   // Checks
   // ******************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   chk_bus_ready: assert property (hreadyout && !hresp)
      else $error("slave not ready");
   chk_reset_clock: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rstn |=> q.ctrl[5][F_CSEL+:3] == CSEL_RST && q.ctrl[0][F_CSEL+:3] == CSEL_RST)
      else $error("port not on clock block zero after reset");
   chk_link_pins: assert property (q.link_en |=> pin_oe_n[31:28] == 4'hf)
      else $error("link pins still driven");
   chk_count_wrap: assert property (
      q.ctrl[0][F_EN] && q.ctrl[0][F_CSEL+:3] == 3'h0 && q.cnt[0] == 16'hffff
      |=> q.cnt[0] == 16'h0000)
      else $error("counter did not wrap");
   chk_stamp_take: assert property (q.evt[3] |-> q.stamp[3] == $past(q.cnt[3]))
      else $error("timestamp mismatch");
   chk_oc_release: assert property (
      q.ctrl[2][F_EN] && q.ctrl[2][F_OUT] && q.ctrl[2][F_OC] && !q.ctrl[0][F_EN]
      |=> pin_oe_n[0] == $past(q.drv[2][0]) && !pin_o[0])
      else $error("open collector pin misdriven");
   chk_input_hiz: assert property (q.ctrl[1][F_EN] && !q.ctrl[1][F_OUT] |=> pin_oe_n[1])
      else $error("input port drives pin");
   chk_timed_wait: assert property (
      q.busy[2] && q.ctrl[2][F_TIMED] && q.cnt[2] != q.tim[2] && !q.awr
      |=> q.left[2] == $past(q.left[2]))
      else $error("transfer before programmed count");
   chk_cond_wait: assert property (
      q.busy[0] && !q.ctrl[0][F_OUT] && q.ctrl[0][F_COND+:2] == COND_NE
      && q.s2[0] == q.rdat[0][0] && !q.awr ##0 q.left[0] != 6'h0
      |=> q.left[0] == $past(q.left[0]))
      else $error("sample taken before condition");
endmodule

//--- tio_pkg.sv
// Shared constants, register map and state layout of the timed I/O port block
package tio_pkg;
   // ******************************
   // Port geometry
   // ******************************
   localparam int unsigned NPORT = 6;
   localparam int unsigned NCLK  = 6;
   localparam int unsigned PW [NPORT] = '{1, 1, 4, 8, 16, 32};
   localparam int unsigned PB [NPORT] = '{0, 1, 0, 0, 0, 0};
   localparam int unsigned LINK_LO = 28;
   // ******************************
   // Register map
   // ******************************
   localparam logic [3:0]  AREA_PORT = 4'h0;
   localparam logic [3:0]  AREA_CLK  = 4'h1;
   localparam logic [11:0] OFS_GLOB  = 12'h200;
   localparam logic [1:0]  REG_CTRL  = 2'h0;
   localparam logic [1:0]  REG_DATA  = 2'h1;
   localparam logic [1:0]  REG_TIME  = 2'h2;
   localparam logic [1:0]  REG_STAMP = 2'h3;
   // Control fields
   localparam int unsigned F_EN = 0;
   localparam int unsigned F_OUT = 1;
   localparam int unsigned F_OC = 2;
   localparam int unsigned F_TIMED = 3;
   localparam int unsigned F_SIN = 4;
   localparam int unsigned F_SOUT = 5;
   localparam int unsigned F_COND = 6;
   localparam int unsigned F_CSEL = 8;
   localparam int unsigned F_BUSY = 16;
   localparam logic [1:0] COND_NONE = 2'h0;
   localparam logic [1:0] COND_EQ   = 2'h1;
   localparam logic [1:0] COND_NE   = 2'h2;
   localparam logic [1:0] SRC_REF   = 2'h0;
   localparam logic [1:0] SRC_PIN0  = 2'h1;
   localparam logic [1:0] SRC_PIN1  = 2'h2;
   localparam logic [2:0] CSEL_RST  = 3'h0;
   // ******************************
   // Block state
   // ******************************
   typedef struct packed {
      logic [NPORT-1:0][10:0] ctrl;
      logic [NPORT-1:0][31:0] xfer;
      logic [NPORT-1:0][31:0] rdat;
      logic [NPORT-1:0][31:0] drv;
      logic [NPORT-1:0][15:0] tim;
      logic [NPORT-1:0][15:0] cnt;
      logic [NPORT-1:0][15:0] stamp;
      logic [NPORT-1:0][5:0]  left;
      logic [NPORT-1:0]       busy;
      logic [NPORT-1:0]       evt;
      logic [NPORT-1:0]       sout;
      logic [NCLK-1:0][9:0]   ccfg;
      logic [NCLK-1:0][7:0]   cdiv;
      logic [31:0]            s1;
      logic [31:0]            s2;
      logic [NPORT-1:0]       t1;
      logic [NPORT-1:0]       t2;
      logic [1:0]             pprev;
      logic                   link_en;
      logic [11:0]            aaddr;
      logic                   awr;
      logic [31:0]            rdata;
      logic                   rdy;
      logic [31:0]            pin_o;
      logic [31:0]            pin_oe_n;
   } tio_state_s;
endpackage

//--- tio_pin_model.sv
// External hardware on the port pins: input levels, strobes and a pin clock
`timescale 1ns/1ns
module tio_pin_model (
   input  wire logic        ref_clk,
   input  wire logic [31:0] pin_o,
   input  wire logic [31:0] pin_oe_n,
   input  wire logic [31:0] ext_val,
   input  wire logic [5:0]  ext_rdy,
   input  wire logic        clk_go,
   output logic      [31:0] pin_i,
   output logic      [5:0]  strobe_input
);
   logic [1:0] ph;
   logic       pclk;
   initial begin
      ph = 2'h0;
      pclk = 1'b0;
      strobe_input = 6'h0;
   end
   // ******************************
   // Pin clock and strobes
   // ******************************
   // Clock rests low between bursts, as a real source would
   always @(posedge ref_clk) begin
      ph <= clk_go ? ph + 2'h1 : 2'h0;
      pclk <= clk_go ? (ph == 2'h3 ? ~pclk : pclk) : 1'b0;
      strobe_input <= ext_rdy;
   end
   // ******************************
   // Pin levels
   // ******************************
   // Released pins show the far side; with nothing there the pull-down wins
   always_comb begin
      pin_i = (pin_o & ~pin_oe_n) | (ext_val & pin_oe_n);
      if (pin_oe_n[0] && clk_go) begin
         pin_i[0] = pclk;
      end
   end
endmodule

//--- timed_io_port_tb_top.sv
// Register-level testbench of the timed I/O port block
`timescale 1ns/1ns
module timed_io_port_tb_top;
   logic ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_go = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, ext_val = 32'h0, v, a;
   logic [1:0]  htrans = 2'h0;
   logic [5:0]  ext_rdy = 6'h0;
   wire  logic [31:0] hrdata, pin_i, pin_o, pin_oe_n;
   wire  logic [5:0]  strobe_input, strobe_output, port_event;
   wire  logic        hreadyout, hresp;
   int failures = 0, checks = 0, cyc = 0, ev4 = 0, ev3 = 0, n;
   always #25 ref_clk = ~ref_clk;
   timed_io_port DUT (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .strobe_input(strobe_input), .strobe_output(strobe_output),
      .port_event(port_event));
   tio_pin_model far (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .ext_val(ext_val), .ext_rdy(ext_rdy), .clk_go(clk_go), .pin_i(pin_i),
      .strobe_input(strobe_input));
   // ******************************
   // Bus tasks and checks
   // ******************************
   task automatic xfer(input logic [11:0] ad, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h0, ad};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      logic [31:0] q;
      xfer(ad, 1'b1, d, q);
   endtask
   task automatic rd(input logic [11:0] ad, output logic [31:0] q);
      xfer(ad, 1'b0, 32'h0, q);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic print_verdict();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (port_event[4] === 1'b1) ev4++;
      if (port_event[3] === 1'b1) ev3++;
      if (cyc == 6000) begin
         failures++;
         print_verdict();
      end
   end
   // ******************************
   // Tests
   // ******************************
   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int p = 0; p < 6; p++) begin
         rd(12'(p * 16), v); chk(v, 32'h0);
      end
      rd(12'h300, v); chk(v, 32'h0);
      chk(pin_oe_n, 32'hffffffff);
      done("reset");
      wr(12'h030, 32'h3);
      wr(12'h034, 32'h44332211);
      for (n = 0; n < 60 && pin_o[7:0] !== 8'h11; n++) @(posedge ref_clk);
      chk(pin_oe_n[7:0], 32'h0);
      @(posedge ref_clk); chk(pin_o[7:0], 32'h22);
      @(posedge ref_clk); chk(pin_o[7:0], 32'h33);
      @(posedge ref_clk); chk(pin_o[7:0], 32'h44);
      // The event pulses the cycle before the last byte reaches the pins, so it is counted per edge
      chk(ev3, 32'h1);
      rd(12'h03c, v);
      rd(12'h038, a);
      chk(32'(v != 0 && a - v < 32), 32'h1);
      rd(12'h038, v);
      rd(12'h038, a); chk(a - v, 32'h3);
      done("output");
      wr(12'h020, 32'h1);
      wr(12'h034, 32'hffffffff);
      for (n = 0; n < 60 && pin_o[7:4] !== 4'hf; n++) @(posedge ref_clk);
      chk(pin_oe_n[3:0], 32'hf);
      chk(pin_o[7:4], 32'hf);
      wr(12'h020, 32'h7);
      wr(12'h024, 32'haaaaaaaa);
      for (n = 0; n < 60 && pin_oe_n[3:0] !== 4'ha; n++) @(posedge ref_clk);
      chk(pin_oe_n[3:0], 32'ha);
      rd(12'h020, v); chk(v[10:0], 32'h7);
      rd(12'h030, v); chk(v[10:0], 32'h3);
      wr(12'h020, 32'h0);
      wr(12'h030, 32'h0);
      done("sharing");
      ext_val <= 32'h0000beef;
      wr(12'h040, 32'h11);
      wr(12'h044, 32'h0);
      repeat (20) @(posedge ref_clk);
      chk(ev4, 32'h0);
      ext_rdy <= 6'h10;
      for (n = 0; n < 60 && ev4 == 0; n++) @(posedge ref_clk);
      chk(ev4, 32'h1);
      rd(12'h044, v); chk(v, 32'hbeefbeef);
      wr(12'h040, 32'h0);
      done("input");
      ext_val <= 32'h0;
      wr(12'h200, 32'h1);
      wr(12'h050, 32'h3);
      wr(12'h054, 32'h0);
      for (n = 0; n < 60 && pin_oe_n[0] !== 1'b0; n++) @(posedge ref_clk);
      chk(pin_oe_n[31:28], 32'hf);
      chk(pin_oe_n[27:0], 32'h0);
      wr(12'h050, 32'h0);
      done("link");
      wr(12'h100, 32'hff);
      rd(12'h100, v); chk(v, 32'h0);
      wr(12'h104, 32'h101);
      rd(12'h104, v); chk(v, 32'h101);
      wr(12'h010, 32'h101);
      rd(12'h018, v); chk(v, 32'h0);
      clk_go <= 1'b1;
      repeat (64) @(posedge ref_clk);
      clk_go <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(12'h018, v); chk(v, 32'h4);
      done("clock");
      print_verdict();
   end
endmodule
